// file: design/pcf_cfg_fwd.v
// Configuration forwarding engine of a PCI-to-PCI bridge
// Function
// (RL1) Type 0 made only downstream, never primary
// (RL2) Conversion is delayed, one 32-bit phase
// (RL3) Claim: type 1, secondary bus, config command
// (RL4) Rewrite low bits, select lines, clear device
// (RL5) Devices 0..15 drive one-hot select line
// (RL6) Devices 10h..1Eh: zero select, still converted
// (RL7) Device 1Fh: special if register zero
// (RL8) Unselected converted cycle may master abort
// (RL9) Deeper-bus type 1 passes unmodified downstream
// (RL10) Downstream forward: bus above secondary, within subordinate
// (RL11) Upstream forward: broadcast write outside range
// (RL12) Forwarded type 1 writes delayed, one phase
// (RL13) Incoming special cycles ignored, never forwarded
// (RL14) Broadcast write to matching bus becomes special
// (RL15) Special: swap command, keep address, data
// (RL16) After master abort, ready on retry; with master_abort_mode set, non-special cycles get target abort
// (RL17) Multi-phase special request gets disconnect
// (RL18) Register, function, device, bus address fields
// (RL19) Special-cycle master abort is not recorded
// (RL20) Unmatched type 1 cycles are not claimed
// (RL21) Initiator repeats retried cycle identically
`timescale 1ns/100ps
`include "pcf_fwd_regs.vh"

module pcf_cfg_fwd (
	clock,
	sys_rst,
	pri_bus_num,
	sec_bus_num,
	sub_bus_num,
	master_abort_mode,
	pri_req,
	pri_ad,
	primary_cmd_byte_enables,
	pri_wdata,
	pri_be,
	pri_multi,
	sec_req,
	sec_ad,
	sec_cmd,
	sec_wdata,
	sec_be,
	sec_multi,
	pri_claim,
	pri_retry,
	pri_trdy,
	pri_stop,
	pri_tabort,
	pri_rdata,
	sec_claim,
	sec_retry,
	sec_trdy,
	sec_stop,
	sec_tabort,
	sec_rdata,
	fwd_req,
	fwd_to_pri,
	fwd_special,
	fwd_addr,
	fwd_cmd,
	fwd_data,
	fwd_be,
	fwd_done,
	fwd_mabort,
	fwd_tabort,
	fwd_rdata,
	pri_rcv_mabort,
	sec_rcv_mabort
);
	input wire clock;
	input wire sys_rst;
	input wire [7:0] pri_bus_num;
	input wire [7:0] sec_bus_num;
	input wire [7:0] sub_bus_num;
	input wire master_abort_mode;
	input wire pri_req;
	input wire [31:0] pri_ad;
	input wire [3:0] primary_cmd_byte_enables;
	input wire [31:0] pri_wdata;
	input wire [3:0] pri_be;
	input wire pri_multi;
	input wire sec_req;
	input wire [31:0] sec_ad;
	input wire [3:0] sec_cmd;
	input wire [31:0] sec_wdata;
	input wire [3:0] sec_be;
	input wire sec_multi;
	output reg pri_claim;
	output reg pri_retry;
	output reg pri_trdy;
	output reg pri_stop;
	output reg pri_tabort;
	output reg [31:0] pri_rdata;
	output reg sec_claim;
	output reg sec_retry;
	output reg sec_trdy;
	output reg sec_stop;
	output reg sec_tabort;
	output reg [31:0] sec_rdata;
	output reg fwd_req;
	output reg fwd_to_pri;
	output reg fwd_special;
	output reg [31:0] fwd_addr;
	output reg [3:0] fwd_cmd;
	output reg [31:0] fwd_data;
	output reg [3:0] fwd_be;
	input wire fwd_done;
	input wire fwd_mabort;
	input wire fwd_tabort;
	input wire [31:0] fwd_rdata;
	output reg pri_rcv_mabort;
	output reg sec_rcv_mabort;

	// ------------------------------------------------------------
	// States of the single delayed-transaction entry
	// ------------------------------------------------------------
	localparam ST_IDLE = 3'h1;
	localparam ST_WAIT = 3'h2;
	localparam ST_DONE = 3'h4;

	reg [2:0] st_r;
	reg [2:0] st_nxt;
	reg ent_sec_r;
	reg [31:0] ent_addr_r;
	reg [3:0] ent_cmd_r;
	reg [31:0] ent_data_r;
	reg [3:0] ent_be_r;
	reg res_tab_r;
	reg [31:0] res_rdata_r;

	wire [15:0] idsel;
	wire [1:0] pri_kind;
	wire [31:0] pri_oaddr;
	wire [3:0] pri_ocmd;
	wire [1:0] sec_kind;
	wire [31:0] sec_oaddr;
	wire [3:0] sec_ocmd;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Repeat of the queued request: same address, command, bytes
	// and, for a write, the same data
	function same_req;
		input [31:0] ad;
		input [3:0] cmd;
		input [31:0] d;
		input [3:0] be;
		input [31:0] e_ad;
		input [3:0] e_cmd;
		input [31:0] e_d;
		input [3:0] e_be;
		begin
			same_req = (ad == e_ad) && (cmd == e_cmd) && (be == e_be) &&
				((cmd == `PCF_CMD_CFG_RD) || (d == e_d));
		end
	endfunction

	// Termination for one side: {claim,retry,trdy,stop,tabort}
	function [4:0] answer;
		input hit;
		input fin;
		input multi;
		input tab;
		begin
			if (!hit) begin
				answer = 5'h00;
			end else begin
				answer = {1'b1, !fin, fin && !tab,
					fin && !tab && multi, fin && tab};
			end
		end
	endfunction

	// ------------------------------------------------------------
	// Decoders
	// ------------------------------------------------------------
	// Select pattern from the primary device number field
	pcf_idsel u_idsel (
		.dev(pri_ad[`PCF_DEV_HI:`PCF_DEV_LO]),
		.sel(idsel)
	);

	// (RL1) conversion downstream only
	pcf_decode #(.UP(0)) u_dec_down (
		.ad(pri_ad),
		.cmd(primary_cmd_byte_enables),
		.pri_bus(pri_bus_num),
		.sec_bus(sec_bus_num),
		.sub_bus(sub_bus_num),
		.idsel(idsel),
		.kind(pri_kind),
		.out_addr(pri_oaddr),
		.out_cmd(pri_ocmd)
	);

	// Upstream side never converts, so the select input is unused
	pcf_decode #(.UP(1)) u_dec_up (
		.ad(sec_ad),
		.cmd(sec_cmd),
		.pri_bus(pri_bus_num),
		.sec_bus(sec_bus_num),
		.sub_bus(sub_bus_num),
		.idsel(16'h0000),
		.kind(sec_kind),
		.out_addr(sec_oaddr),
		.out_cmd(sec_ocmd)
	);

	// ------------------------------------------------------------
	// Request qualification
	// ------------------------------------------------------------
	// (RL13) special cycles not claimed
	// (RL20) unmatched cycles unclaimed
	wire pri_hit = pri_req && (pri_kind != `PCF_K_NONE);
	wire sec_hit = sec_req && (sec_kind != `PCF_K_NONE);
	// Primary wins when both sides arrive together
	wire take_pri = pri_hit && (st_r == ST_IDLE);
	wire take_sec = sec_hit && !pri_hit && (st_r == ST_IDLE);
	// (RL21) repeat matches entry
	wire pri_rep = !ent_sec_r && same_req(pri_ad,
		primary_cmd_byte_enables, pri_wdata, pri_be,
		ent_addr_r, ent_cmd_r, ent_data_r, ent_be_r);
	wire sec_rep = ent_sec_r && same_req(sec_ad, sec_cmd,
		sec_wdata, sec_be, ent_addr_r, ent_cmd_r, ent_data_r,
		ent_be_r);
	wire fin_pri = pri_hit && pri_rep && (st_r == ST_DONE);
	wire fin_sec = sec_hit && sec_rep && (st_r == ST_DONE);
	wire ent_spec = fwd_special;
	wire [4:0] pri_ans = answer(pri_hit, fin_pri, pri_multi, res_tab_r);
	wire [4:0] sec_ans = answer(sec_hit, fin_sec, sec_multi, res_tab_r);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// (RL2) delayed transaction flow
	// (RL12) forwarded writes delayed
	always @* begin
		case (st_r)
			ST_IDLE: begin
				st_nxt = (take_pri || take_sec) ? ST_WAIT : ST_IDLE;
			end
			ST_WAIT: begin
				st_nxt = fwd_done ? ST_DONE : ST_WAIT;
			end
			ST_DONE: begin
				st_nxt = (fin_pri || fin_sec) ? ST_IDLE : ST_DONE;
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	// State register
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Entry capture and forward request
	// ------------------------------------------------------------
	// Original request kept for matching the initiator's repeat
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ent_sec_r <= 1'b0;
			ent_addr_r <= `PCF_ZERO32;
			ent_cmd_r <= 4'h0;
			ent_data_r <= `PCF_ZERO32;
			ent_be_r <= 4'h0;
			fwd_req <= 1'b0;
			fwd_to_pri <= 1'b0;
			fwd_special <= 1'b0;
			fwd_addr <= `PCF_ZERO32;
			fwd_cmd <= 4'h0;
			fwd_data <= `PCF_ZERO32;
			fwd_be <= 4'h0;
		end else begin
			fwd_req <= take_pri || take_sec;
			if (take_pri) begin
				ent_sec_r <= 1'b0;
				ent_addr_r <= pri_ad;
				ent_cmd_r <= primary_cmd_byte_enables;
				ent_data_r <= pri_wdata;
				ent_be_r <= pri_be;
				// (RL15) command swapped, data kept
				fwd_to_pri <= 1'b0;
				fwd_special <= (pri_kind == `PCF_K_SPEC);
				fwd_addr <= pri_oaddr;
				fwd_cmd <= pri_ocmd;
				fwd_data <= pri_wdata;
				fwd_be <= pri_be;
			end else if (take_sec) begin
				ent_sec_r <= 1'b1;
				ent_addr_r <= sec_ad;
				ent_cmd_r <= sec_cmd;
				ent_data_r <= sec_wdata;
				ent_be_r <= sec_be;
				fwd_to_pri <= 1'b1;
				fwd_special <= (sec_kind == `PCF_K_SPEC);
				fwd_addr <= sec_oaddr;
				fwd_cmd <= sec_ocmd;
				fwd_data <= sec_wdata;
				fwd_be <= sec_be;
			end
		end
	end

	// ------------------------------------------------------------
	// Completion from the target bus
	// ------------------------------------------------------------
	// Result held until the initiator repeats the cycle
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			res_tab_r <= 1'b0;
			res_rdata_r <= `PCF_ZERO32;
			pri_rcv_mabort <= 1'b0;
			sec_rcv_mabort <= 1'b0;
		end else begin
			pri_rcv_mabort <= 1'b0;
			sec_rcv_mabort <= 1'b0;
			if (st_r == ST_WAIT && fwd_done) begin
				if (ent_spec) begin
					// (RL16) special ends ready
					// (RL15) response not returned
					res_tab_r <= 1'b0;
					res_rdata_r <= `PCF_ZERO32;
				end else begin
					// (RL8) master abort accepted
					res_tab_r <= fwd_tabort ||
						(fwd_mabort && master_abort_mode);
					res_rdata_r <= fwd_mabort ? `PCF_ONES32 : fwd_rdata;
				end
				// (RL19) special abort unrecorded
				pri_rcv_mabort <= fwd_mabort && !ent_spec && fwd_to_pri;
				sec_rcv_mabort <= fwd_mabort && !ent_spec && !fwd_to_pri;
			end
		end
	end

	// ------------------------------------------------------------
	// Initiator answers
	// ------------------------------------------------------------
	// Retry until done; then ready or target abort, with disconnect on a ready burst
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pri_claim <= 1'b0;
			pri_retry <= 1'b0;
			pri_trdy <= 1'b0;
			pri_stop <= 1'b0;
			pri_tabort <= 1'b0;
			pri_rdata <= `PCF_ZERO32;
			sec_claim <= 1'b0;
			sec_retry <= 1'b0;
			sec_trdy <= 1'b0;
			sec_stop <= 1'b0;
			sec_tabort <= 1'b0;
			sec_rdata <= `PCF_ZERO32;
		end else begin
			// (RL17) burst gets disconnect
			{pri_claim, pri_retry, pri_trdy, pri_stop,
				pri_tabort} <= pri_ans;
			{sec_claim, sec_retry, sec_trdy, sec_stop,
				sec_tabort} <= sec_ans;
			pri_rdata <= fin_pri ? res_rdata_r : `PCF_ZERO32;
			sec_rdata <= fin_sec ? res_rdata_r : `PCF_ZERO32;
		end
	end

endmodule // pcf_cfg_fwd

// file: design/pcf_fwd_regs.vh
// Constants for the configuration forwarding block
`ifndef PCF_FWD_REGS_VH
`define PCF_FWD_REGS_VH

// ----------------------------------------------------------------
// Bus commands seen in the address phase
// ----------------------------------------------------------------
`define PCF_CMD_SPECIAL 4'h1
`define PCF_CMD_CFG_RD 4'ha
`define PCF_CMD_CFG_WR 4'hb

// ----------------------------------------------------------------
// Configuration address fields
// ----------------------------------------------------------------
`define PCF_TYPE0 2'h0
`define PCF_TYPE1 2'h1
`define PCF_BUS_HI 23
`define PCF_BUS_LO 16
`define PCF_DEV_HI 15
`define PCF_DEV_LO 11
`define PCF_FN_HI 10
`define PCF_FN_LO 8
`define PCF_REG_HI 7
`define PCF_REG_LO 2
`define PCF_DEV_BCAST 5'h1f
`define PCF_FN_BCAST 3'h7
`define PCF_REG_BCAST 6'h00
`define PCF_IDSEL_LINES 16

// ----------------------------------------------------------------
// Decode result codes
// ----------------------------------------------------------------
`define PCF_K_NONE 2'h0
`define PCF_K_T0 2'h1
`define PCF_K_T1 2'h2
`define PCF_K_SPEC 2'h3

// ----------------------------------------------------------------
// Reset and fill values
// ----------------------------------------------------------------
`define PCF_ZERO32 32'h0000_0000
`define PCF_ONES32 32'hffff_ffff

`endif

// file: design/pcf_idsel.v
// One-hot select line decoder for secondary-bus devices
`timescale 1ns/100ps
`include "pcf_fwd_regs.vh"

module pcf_idsel (
	dev,
	sel
);
	input wire [4:0] dev;
	output wire [`PCF_IDSEL_LINES-1:0] sel;

	genvar i;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	// One line per device 0..15; numbers 16 and up leave all low
	generate
		for (i = 0; i < `PCF_IDSEL_LINES; i = i + 1) begin : g_sel
			// (RL5) one-hot select
			// (RL6) high numbers zero
			assign sel[i] = ({27'h000_0000, dev} == i);
		end
	endgenerate

endmodule // pcf_idsel

// file: design/pcf_decode.v
// Address-phase decode of Type 1 configuration cycles
`timescale 1ns/100ps
`include "pcf_fwd_regs.vh"

module pcf_decode #(
	parameter UP = 0
) (
	input wire [31:0] ad,
	input wire [3:0] cmd,
	input wire [7:0] pri_bus,
	input wire [7:0] sec_bus,
	input wire [7:0] sub_bus,
	input wire [15:0] idsel,
	output reg [1:0] kind,
	output reg [31:0] out_addr,
	output reg [3:0] out_cmd
);
	// (RL18) address field split
	wire [7:0] bus = ad[`PCF_BUS_HI:`PCF_BUS_LO];
	wire t1 = (ad[1:0] == `PCF_TYPE1);
	wire rd = (cmd == `PCF_CMD_CFG_RD);
	wire wr = (cmd == `PCF_CMD_CFG_WR);
	wire bcast = (ad[`PCF_DEV_HI:`PCF_DEV_LO] == `PCF_DEV_BCAST) &&
		(ad[`PCF_FN_HI:`PCF_FN_LO] == `PCF_FN_BCAST);
	wire reg0 = (ad[`PCF_REG_HI:`PCF_REG_LO] == `PCF_REG_BCAST);
	wire in_rng = (bus >= sec_bus) && (bus <= sub_bus);
	wire below = (bus > sec_bus) && (bus <= sub_bus);

	// ------------------------------------------------------------
	// Classify and rewrite
	// ------------------------------------------------------------
	// Anything not matched stays unclaimed
	always @* begin
		kind = `PCF_K_NONE;
		out_addr = ad;
		out_cmd = cmd;
		if (UP == 0) begin
			// (RL3) claim for conversion
			if (t1 && (rd || wr) && bus == sec_bus) begin
				// (RL14) downstream special cycle
				if (wr && bcast && reg0) begin
					kind = `PCF_K_SPEC;
					out_cmd = `PCF_CMD_SPECIAL;
				end else begin
					// (RL4) Type 0 rewrite
					// (RL7) non-zero register zero select
					kind = `PCF_K_T0;
					out_addr = {idsel, 5'h00, ad[10:2], `PCF_TYPE0};
				end
			// (RL10) downstream forward test
			// (RL9) address unmodified
			end else if (t1 && (rd || wr) && below) begin
				kind = `PCF_K_T1;
			end
		end else begin
			// (RL14) upstream special cycle
			if (t1 && wr && bcast && reg0 && bus == pri_bus) begin
				kind = `PCF_K_SPEC;
				out_cmd = `PCF_CMD_SPECIAL;
			// (RL11) upstream forward test
			end else if (t1 && wr && bcast && !in_rng) begin
				kind = `PCF_K_T1;
			end
		end
	end

endmodule // pcf_decode

// file: dv/pcf_cfg_fwd_props.sv
// Assertion checker for the configuration forwarding block
`timescale 1ns/100ps
`include "pcf_fwd_regs.vh"
module pcf_chk (
	input wire clock,
	input wire sys_rst,
	input wire [7:0] sec_bus_num,
	input wire [7:0] sub_bus_num,
	input wire pri_req,
	input wire [31:0] pri_ad,
	input wire [3:0] primary_cmd_byte_enables,
	input wire sec_req,
	input wire [3:0] sec_cmd,
	input wire pri_claim,
	input wire pri_retry,
	input wire pri_trdy,
	input wire pri_stop,
	input wire pri_tabort,
	input wire sec_claim,
	input wire fwd_req,
	input wire fwd_to_pri,
	input wire fwd_special,
	input wire [31:0] fwd_addr,
	input wire [3:0] fwd_cmd,
	input wire fwd_done,
	input wire fwd_mabort,
	input wire pri_rcv_mabort,
	input wire sec_rcv_mabort
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// --------------------------------------------------
	// Sequences
	// --------------------------------------------------
	sequence s_sec_hit;
		pri_req && pri_ad[1:0] == `PCF_TYPE1 && pri_ad[23:16] == sec_bus_num
			&& primary_cmd_byte_enables[3:1] == 3'h5;
	endsequence
	sequence s_spec_abort;
		fwd_done && fwd_mabort && fwd_special;
	endsequence
	sequence s_down_fwd;
		fwd_req && !fwd_to_pri && !fwd_special && fwd_addr[1:0] == `PCF_TYPE1;
	endsequence
	// --------------------------------------------------
	// Properties
	// --------------------------------------------------
	claim_on_hit_a: assert property (s_sec_hit |=> pri_claim)
		else $error("secondary bus cycle not claimed");
	one_answer_a: assert property (pri_claim |->
		$onehot({pri_retry, pri_trdy, pri_tabort}))
		else $error("claim without exactly one answer");
	no_type0_up_a: assert property (fwd_req && fwd_to_pri |->
		fwd_addr[1:0] == `PCF_TYPE1)
		else $error("type 0 cycle aimed at primary");
	convert_addr_a: assert property (fwd_req && !fwd_special
		&& fwd_addr[1:0] == `PCF_TYPE0 |-> fwd_addr[15:11] == 5'h00
		&& $countones(fwd_addr[31:16]) <= 1)
		else $error("bad converted address");
	down_range_a: assert property (s_down_fwd |->
		fwd_addr[23:16] > sec_bus_num && fwd_addr[23:16] <= sub_bus_num)
		else $error("forwarded bus out of range");
	special_cmd_a: assert property (fwd_req && fwd_special |->
		fwd_cmd == `PCF_CMD_SPECIAL)
		else $error("special cycle without special command");
	spec_abort_quiet_a: assert property (s_spec_abort |=>
		!pri_rcv_mabort && !sec_rcv_mabort)
		else $error("special cycle abort recorded");
	abort_recorded_a: assert property (fwd_done && fwd_mabort
		&& !fwd_special && !fwd_to_pri |=> sec_rcv_mabort)
		else $error("secondary abort not recorded");
	special_ignored_a: assert property (sec_req
		&& sec_cmd == `PCF_CMD_SPECIAL |=> !sec_claim)
		else $error("incoming special cycle claimed");
	stop_with_data_a: assert property (pri_stop |-> pri_trdy)
		else $error("disconnect without data");
	single_fwd_a: assert property (fwd_req |=> !fwd_req [*3])
		else $error("second forward while one outstanding");
	type0_refused_a: assert property (pri_req
		&& pri_ad[1:0] != `PCF_TYPE1 |=> !pri_claim)
		else $error("non type 1 cycle claimed");
endmodule // pcf_chk

bind pcf_cfg_fwd pcf_chk u_chk (.clock, .sys_rst, .sec_bus_num, .sub_bus_num,
	.pri_req, .pri_ad, .primary_cmd_byte_enables, .sec_req, .sec_cmd,
	.pri_claim, .pri_retry, .pri_trdy, .pri_stop, .pri_tabort, .sec_claim,
	.fwd_req, .fwd_to_pri, .fwd_special, .fwd_addr, .fwd_cmd, .fwd_done,
	.fwd_mabort, .pri_rcv_mabort, .sec_rcv_mabort);

// file: dv/pcf_eng_model.sv
// Behavioural forwarding engine on the destination bus
`timescale 1ns/100ps
module pcf_eng_model (
	input wire clock,
	input wire sys_rst,
	input wire fwd_req,
	input wire [7:0] dly,
	input wire mab,
	input wire tab,
	input wire [31:0] rd,
	output reg fwd_done,
	output reg fwd_mabort,
	output reg fwd_tabort,
	output reg [31:0] fwd_rdata
);
	integer cnt_r;
	// Answer once, dly cycles after the request; noise elsewhere
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= 0;
			fwd_done <= 1'h0;
			fwd_mabort <= 1'h0;
			fwd_tabort <= 1'h0;
			fwd_rdata <= 32'h0000_0000;
		end else begin
			if (fwd_req)
				cnt_r <= dly;
			else if (cnt_r > 0)
				cnt_r <= cnt_r - 1;
			// unselected or special ends in master abort
			if (cnt_r == 1 && !fwd_req) begin
				fwd_done <= 1'h1;
				fwd_mabort <= mab;
				fwd_tabort <= tab;
				fwd_rdata <= rd;
			end else begin
				fwd_done <= 1'h0;
				fwd_mabort <= ~fwd_mabort;
				fwd_tabort <= ~fwd_tabort;
				fwd_rdata <= ~fwd_rdata;
			end
		end
	end
endmodule // pcf_eng_model

// file: dv/tb_top.sv
// Self-checking bench for the configuration forwarding block
`timescale 1ns/100ps
`include "pcf_fwd_regs.vh"
module tb_top;
	reg clock, sys_rst, master_abort_mode, pri_req, pri_multi, sec_req;
	reg sec_multi, mab, tab;
	reg [7:0] pri_bus_num, sec_bus_num, sub_bus_num, dly;
	reg [8:0] r9;
	reg [13:0] r14;
	reg [31:0] pri_ad, pri_wdata, sec_ad, sec_wdata, rd, e_addr;
	reg [3:0] primary_cmd_byte_enables, pri_be, sec_cmd, sec_be, e_cmd;
	wire pri_claim, pri_retry, pri_trdy, pri_stop, pri_tabort;
	wire sec_claim, sec_retry, sec_trdy, sec_stop, sec_tabort;
	wire fwd_req, fwd_to_pri, fwd_special, fwd_done, fwd_mabort, fwd_tabort;
	wire pri_rcv_mabort, sec_rcv_mabort;
	wire [31:0] pri_rdata, sec_rdata, fwd_addr, fwd_data, fwd_rdata;
	wire [3:0] fwd_cmd, fwd_be;
	integer mismatches, num_checks, cycles, n_pm, n_sm, i, e_kind;
	wire [36:0] ans0 = {pri_claim, pri_retry, pri_trdy, pri_stop, pri_tabort,
		pri_rdata};
	wire [36:0] ans1 = {sec_claim, sec_retry, sec_trdy, sec_stop, sec_tabort,
		sec_rdata};

	pcf_cfg_fwd uut (.clock, .sys_rst, .pri_bus_num, .sec_bus_num,
		.sub_bus_num, .master_abort_mode, .pri_req, .pri_ad,
		.primary_cmd_byte_enables, .pri_wdata, .pri_be, .pri_multi, .sec_req,
		.sec_ad, .sec_cmd, .sec_wdata, .sec_be, .sec_multi, .pri_claim,
		.pri_retry, .pri_trdy, .pri_stop, .pri_tabort, .pri_rdata, .sec_claim,
		.sec_retry, .sec_trdy, .sec_stop, .sec_tabort, .sec_rdata, .fwd_req,
		.fwd_to_pri, .fwd_special, .fwd_addr, .fwd_cmd, .fwd_data, .fwd_be,
		.fwd_done, .fwd_mabort, .fwd_tabort, .fwd_rdata, .pri_rcv_mabort,
		.sec_rcv_mabort);
	pcf_eng_model u_eng (.clock, .sys_rst, .fwd_req, .dly, .mab, .tab, .rd,
		.fwd_done, .fwd_mabort, .fwd_tabort, .fwd_rdata);

	// --------------------------------------------------
	// Clock, watchdog and abort pulse counters
	// --------------------------------------------------
	initial begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles = cycles + 1;
		n_pm = n_pm + pri_rcv_mabort;
		n_sm = n_sm + sec_rcv_mabort;
		if (cycles == 5000) begin
			mismatches = mismatches + 1;
			results;
		end
	end

	// --------------------------------------------------
	// Tasks
	// --------------------------------------------------
	task check(input [39:0] seen, input [39:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task results;
		begin
			$display("checks %0d mismatches %0d", num_checks, mismatches);
			if (mismatches == 0 && num_checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// Reference decode: kind 0 none, 1 convert, 2 type 1, 3 special
	task model(input integer side, input [31:0] ad, input [3:0] cmd);
		integer bus, dev, bc;
		begin
			bus = ad[23:16];
			dev = ad[15:11];
			bc = dev == 31 && ad[10:8] == 7;
			e_addr = ad;
			e_cmd = cmd;
			e_kind = 0;
			if (ad[1:0] == 2'h1 && side == 0 && cmd[3:1] == 3'h5) begin
				if (bus == sec_bus_num && cmd[0] && bc && ad[7:2] == 0)
					e_kind = 3;
				else if (bus == sec_bus_num) begin
					e_kind = 1;
					e_addr = {16'h0000, 5'h00, ad[10:2], 2'h0};
					if (dev < 16)
						e_addr[16 + dev] = 1'h1;
				end else if (bus > sec_bus_num && bus <= sub_bus_num)
					e_kind = 2;
			end else if (ad[1:0] == 2'h1 && side == 1 && cmd == 4'hb && bc) begin
				if (bus == pri_bus_num && ad[7:2] == 0)
					e_kind = 3;
				else if (bus < sec_bus_num || bus > sub_bus_num)
					e_kind = 2;
			end
			if (e_kind == 3)
				e_cmd = `PCF_CMD_SPECIAL;
		end
	endtask
	// Present one address and data phase on the chosen side
	task issue(input integer side, input [31:0] ad, input [3:0] cmd,
		input [31:0] wd, input multi);
		begin
			@(negedge clock);
			if (side == 0) begin
				{pri_req, pri_ad, primary_cmd_byte_enables} = {1'h1, ad, cmd};
				{pri_wdata, pri_be, pri_multi} = {wd, wd[3:0], multi};
			end else begin
				{sec_req, sec_ad, sec_cmd} = {1'h1, ad, cmd};
				{sec_wdata, sec_be, sec_multi} = {wd, wd[3:0], multi};
			end
			@(negedge clock);
			pri_req = 1'h0;
			sec_req = 1'h0;
		end
	endtask
	// Whole delayed transaction: first try, far answer, repeat; fl multi,ma,ta
	task run(input integer side, input [31:0] ad, input [3:0] cmd,
		input [2:0] fl);
		reg [31:0] wd, msk;
		reg [36:0] ex, ans;
		integer k, pm, sm;
		begin
			wd = $urandom;
			rd = $urandom;
			{mab, tab} = fl[1:0];
			dly = 1 + $urandom % 6;
			pm = n_pm;
			sm = n_sm;
			model(side, ad, cmd);
			issue(side, ad, cmd, wd, fl[2]);
			if (e_kind == 0) begin
				check({fwd_req, side ? ans1 : ans0}, 0);
			end else begin
				check({fwd_req, side ? ans1 : ans0}, {6'h38, 32'h0000_0000});
				check({fwd_to_pri, fwd_special, fwd_cmd, fwd_addr},
					{side[0], e_kind == 3, e_cmd, e_addr});
				check({fwd_data, fwd_be}, {wd, wd[3:0]});
				for (k = 0; k < 40 && !fwd_done; k = k + 1)
					@(negedge clock);
				issue(side, ad, cmd, wd, fl[2]);
				msk = cmd[0] ? 32'h0000_0000 : 32'hffff_ffff;
				// Held result data rides with any final answer, abort too
				ex = {3'h5, fl[2], 1'h0, mab ? 32'hffff_ffff : rd};
				if (e_kind != 3 && (tab || mab && master_abort_mode))
					ex[36:32] = 5'h11;
				ans = side ? ans1 : ans0;
				check({ans[36:32], ans[31:0] & msk},
					{ex[36:32], ex[31:0] & msk});
				k = (mab && e_kind != 3) ? (side ? 2 : 1) : 0;
				check((n_pm - pm) * 2 + n_sm - sm, k);
			end
		end
	endtask

	// --------------------------------------------------
	// Main sequence
	// --------------------------------------------------
	initial begin
		{mismatches, num_checks, cycles, n_pm, n_sm} = 0;
		{sys_rst, pri_req, sec_req, pri_multi, sec_multi} = 5'h10;
		{master_abort_mode, mab, tab, dly} = 11'h000;
		{pri_ad, pri_wdata, sec_ad, sec_wdata, rd} = 0;
		{primary_cmd_byte_enables, pri_be, sec_cmd, sec_be} = 16'h0000;
		{pri_bus_num, sec_bus_num, sub_bus_num} = 24'h02_0509;
		i = $urandom(74501);
		repeat (4) @(posedge clock);
		@(negedge clock);
		sys_rst = 1'h0;
		// every device number on the secondary bus
		for (i = 0; i < 32; i = i + 1) begin
			r9 = (i == 31) ? 9'h1c0 : $urandom;
			run(0, {8'h00, sec_bus_num, i[4:0], r9, 2'h1}, {3'h5, i[0]},
				{i[1], i > 15, 1'h0});
		end
		run(0, 32'h0005_ff05, 4'hb, 3'h2);
		run(0, 32'h0005_ff01, 4'ha, 3'h6);
		$display("test 1 done");
		// bus numbers around the forwarded range
		for (i = 4; i < 11; i = i + 1) begin
			r14 = $urandom;
			run(0, {8'h00, i[7:0], r14, 2'h1}, {3'h5, i[0]}, {i[1], 1'h0, i == 7});
		end
		$display("test 2 done");
		run(0, 32'h0005_0800, 4'ha, 3'h0);
		run(0, 32'h0005_0801, 4'h1, 3'h0);
		run(1, 32'h0000_0800, 4'ha, 3'h0);
		run(1, 32'h0002_ff01, 4'h1, 3'h0);
		run(1, 32'h0002_ff01, 4'hb, 3'h6);
		run(1, 32'h0020_ff05, 4'hb, 3'h2);
		run(1, 32'h0007_ff01, 4'hb, 3'h0);
		run(1, 32'h0020_ff01, 4'ha, 3'h0);
		$display("test 3 done");
		// abort mode: converted cycle aborts, special still completes
		master_abort_mode = 1'h1;
		run(0, 32'h0005_a005, 4'ha, 3'h2);
		run(0, 32'h0005_ff01, 4'hb, 3'h6);
		$display("test 4 done");
		results;
	end
endmodule // tb_top
